// ---- hw/ccm_edge_prescale.sv ----
// Purpose: Counts qualifying input edges and fires once per ratio
// Assumes: ratio is 1, 4 or 16; edge_seen is one cycle per edge
// Notes:   clear restarts the count from zero
`timescale 1ns/10ps
module ccm_edge_prescale
    import ccm_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       clear,
    input  wire logic       edge_seen,
    input  wire logic [4:0] ratio,
    output logic            fire
);

    logic [4:0] count_r;
    logic [4:0] count_nxt;

    always_comb
    begin
        fire      = edge_seen && (count_r == ratio - 5'h01);
        count_nxt = count_r;
        if (clear)
        begin
            count_nxt = 5'h00;
        end
        else if (fire)
        begin
            count_nxt = 5'h00;
        end
        else if (edge_seen)
        begin
            count_nxt = count_r + 5'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count_r <= 5'h00;
        end
        else
        begin
            count_r <= count_nxt;
        end
    end

    property p_count_below_ratio;
        @(posedge core_clk) disable iff (!rstn)
        !clear |-> count_r < ratio;
    endproperty
    a_count_below_ratio: assert property (p_count_below_ratio)
        else $error("edge prescale count reached its ratio");

endmodule // ccm_edge_prescale

// ---- hw/ccm_pkg.sv ----
// Purpose: Shared constants and types of the capture/compare/PWM unit
// Assumes: 8-bit register port, one 200 MHz clock
// Notes:   Register offsets are byte addresses on the plain port
package ccm_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int TMR_W  = 16;
    localparam int DUTY_W = 10;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CONTROL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_DUTY_HIGH = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_CC_LOW    = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_CC_HIGH   = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_MASK      = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_TIMER_SEL = 4'h6;

    // Field positions
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_DUTY_LSB  = 4;
    localparam int STAT_EVENT_BIT = 0;
    localparam int STAT_TRIG_BIT  = 1;
    localparam int STAT_W         = 2;

    // Reset values
    localparam logic [3:0]        MODE_RST      = 4'h0;
    localparam logic [1:0]        DUTY_LOW_RST  = 2'h0;
    localparam logic [7:0]        DUTY_HIGH_RST = 8'h00;
    localparam logic [TMR_W-1:0]  CC_RST        = 16'h0000;
    localparam logic [STAT_W-1:0] STATUS_RST    = 2'h0;
    localparam logic [STAT_W-1:0] MASK_RST      = 2'h0;
    localparam logic              TSEL_RST      = 1'b0;

    // Mode codes
    localparam logic [3:0] MC_OFF        = 4'h0;
    localparam logic [3:0] MC_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MC_CAP_FALL   = 4'h4;
    localparam logic [3:0] MC_CAP_RISE   = 4'h5;
    localparam logic [3:0] MC_CAP_RISE4  = 4'h6;
    localparam logic [3:0] MC_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MC_CMP_SET    = 4'h8;
    localparam logic [3:0] MC_CMP_CLR    = 4'h9;
    localparam logic [3:0] MC_CMP_IRQ    = 4'hA;
    localparam logic [3:0] MC_CMP_SPEC   = 4'hB;
    localparam logic [1:0] MC_PWM_TOP    = 2'h3;

    // Edge prescale ratios
    localparam logic [4:0] RATIO_1  = 5'h01;
    localparam logic [4:0] RATIO_4  = 5'h04;
    localparam logic [4:0] RATIO_16 = 5'h10;

    typedef enum logic [3:0] {
        CCM_OFF, CCM_CMP_TOGGLE, CCM_CAP_FALL, CCM_CAP_RISE,
        CCM_CAP_RISE4, CCM_CAP_RISE16, CCM_CMP_SET, CCM_CMP_CLR,
        CCM_CMP_IRQ, CCM_CMP_SPEC, CCM_PWM
    } ccm_mode_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ccm_bus_req_type;

    typedef struct packed {
        logic [TMR_W-1:0] one;
        logic [TMR_W-1:0] three;
    } ccm_timers_type;

    typedef struct packed {
        logic              pin_meta;
        logic              pin_sync;
        logic              pin_prev;
        logic [3:0]        mode;
        logic [1:0]        duty_low;
        logic [7:0]        duty_high;
        logic [TMR_W-1:0]  cc;
        logic [STAT_W-1:0] status;
        logic [STAT_W-1:0] mask;
        logic              tsel;
        logic [DATA_W-1:0] rdata;
        logic              out_level;
        logic              match_prev;
        logic [DUTY_W-1:0] pwm_duty;
        logic              clr_one;
        logic              clr_three;
        logic              conv_start;
    } ccm_core_state_type;

endpackage

// ---- hw/ccm_unit.sv ----
// Purpose: Capture, compare and PWM mode control of unit two
// Assumes: Timers and PWM time base are on core_clk; pin is asynchronous
// Notes:   Compare register doubles as capture register
`timescale 1ns/10ps

// Overview of operation
// - Mode 0000 switches the unit off and resets its internal state.
// - Mode 0010 compares and inverts the output pin on each match.
// - Mode 0100 captures on falling edges, 0101 on rising edges.
// - Mode 0110 captures every fourth rising edge, 0111 every sixteenth.
// - Mode 1000 drives pin low on entry, high on match.
// - Mode 1001 drives pin high on entry, low on match.
// - Mode 1010 only raises the interrupt flag on match; pin holds.
// - Mode 1011 match clears the selected timer, one or three.
// - Special trigger starts a conversion only with converter enabled.
// - Modes 11xx are PWM; duty field gives the two low bits.
// - PWM takes the eight high duty bits from the high-byte register.
// - Duty field has no effect in capture and compare modes.
// - Control bits 7 and 6 are unimplemented and read zero.
module ccm_unit
    import ccm_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire ccm_bus_req_type   bus_req,
    output logic [DATA_W-1:0]      bus_rdata,
    input  wire ccm_timers_type    timers,
    input  wire logic              converter_enabled,
    input  wire logic [DUTY_W-1:0] pwm_time,
    input  wire logic              pwm_period_start,
    input  wire logic              capture_compare_pin_in,
    output logic                   capture_compare_pin_out,
    output logic                   capture_compare_pin_oe,
    output logic                   timer_one_clear,
    output logic                   timer_three_clear,
    output logic                   conversion_start,
    output logic                   irq
);

    ccm_core_state_type st_r;
    ccm_core_state_type st_nxt;

    ccm_mode_type       mode;
    ccm_mode_type       new_mode;
    logic [TMR_W-1:0]   sel_timer;
    logic               rise_seen;
    logic               fall_seen;
    logic               cap_edge;
    logic               cap_fire;
    logic               match_now;
    logic               match_fire;
    logic               ctrl_wr;
    logic               mode_change;
    logic               off_wr;
    logic [4:0]         ratio;
    logic               is_capture;
    logic               is_compare;
    logic [STAT_W-1:0]  stat_set;
    logic [STAT_W-1:0]  stat_clr;

    function automatic ccm_mode_type decode(input logic [3:0] code);
        ccm_mode_type m;
        m = CCM_OFF;
        if (code[3:2] == MC_PWM_TOP)
        begin
            m = CCM_PWM;
        end
        else
        begin
            case (code)
                MC_CMP_TOGGLE: m = CCM_CMP_TOGGLE;
                MC_CAP_FALL:   m = CCM_CAP_FALL;
                MC_CAP_RISE:   m = CCM_CAP_RISE;
                MC_CAP_RISE4:  m = CCM_CAP_RISE4;
                MC_CAP_RISE16: m = CCM_CAP_RISE16;
                MC_CMP_SET:    m = CCM_CMP_SET;
                MC_CMP_CLR:    m = CCM_CMP_CLR;
                MC_CMP_IRQ:    m = CCM_CMP_IRQ;
                MC_CMP_SPEC:   m = CCM_CMP_SPEC;
                default:       m = CCM_OFF;
            endcase
        end
        return m;
    endfunction

    ccm_edge_prescale u_prescale (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .clear     (mode_change),
        .edge_seen (cap_edge),
        .ratio     (ratio),
        .fire      (cap_fire)
    );

    always_comb
    begin
        mode       = decode(st_r.mode);
        ctrl_wr    = bus_req.wr && (bus_req.addr == OFS_CONTROL);
        new_mode   = decode(bus_req.wdata[CTRL_MODE_LSB +: 4]);
        mode_change = ctrl_wr &&
                      (bus_req.wdata[CTRL_MODE_LSB +: 4] != st_r.mode);
        off_wr     = ctrl_wr && (new_mode == CCM_OFF);
        sel_timer  = st_r.tsel ? timers.three : timers.one;
        rise_seen  = st_r.pin_sync && !st_r.pin_prev;
        fall_seen  = !st_r.pin_sync && st_r.pin_prev;
        is_capture = (mode == CCM_CAP_FALL) || (mode == CCM_CAP_RISE) ||
                     (mode == CCM_CAP_RISE4) || (mode == CCM_CAP_RISE16);
        is_compare = (mode == CCM_CMP_TOGGLE) || (mode == CCM_CMP_SET) ||
                     (mode == CCM_CMP_CLR) || (mode == CCM_CMP_IRQ) ||
                     (mode == CCM_CMP_SPEC);
        cap_edge   = 1'b0;
        ratio      = RATIO_1;
        case (mode)
            CCM_CAP_FALL:   cap_edge = fall_seen;
            CCM_CAP_RISE:   cap_edge = rise_seen;
            CCM_CAP_RISE4:
            begin
                cap_edge = rise_seen;
                ratio    = RATIO_4;
            end
            CCM_CAP_RISE16:
            begin
                cap_edge = rise_seen;
                ratio    = RATIO_16;
            end
            default:        cap_edge = 1'b0;
        endcase
        // Edge only, so a stalled timer does not refire every cycle
        match_now  = is_compare && (sel_timer == st_r.cc);
        match_fire = match_now && !st_r.match_prev && !mode_change;
    end

    always_comb
    begin
        st_nxt = st_r;
        stat_set = '0;
        stat_clr = '0;
        st_nxt.pin_meta   = capture_compare_pin_in;
        st_nxt.pin_sync   = st_r.pin_meta;
        st_nxt.pin_prev   = st_r.pin_sync;
        st_nxt.match_prev = match_now;
        st_nxt.clr_one    = 1'b0;
        st_nxt.clr_three  = 1'b0;
        st_nxt.conv_start = 1'b0;
        st_nxt.rdata      = '0;

        // Events
        if (cap_fire && is_capture && !mode_change)
        begin
            st_nxt.cc = sel_timer;
            stat_set[STAT_EVENT_BIT] = 1'b1;
        end
        if (match_fire)
        begin
            stat_set[STAT_EVENT_BIT] = 1'b1;
            case (mode)
                CCM_CMP_TOGGLE: st_nxt.out_level = !st_r.out_level;
                CCM_CMP_SET:    st_nxt.out_level = 1'b1;
                CCM_CMP_CLR:    st_nxt.out_level = 1'b0;
                CCM_CMP_SPEC:
                begin
                    stat_set[STAT_TRIG_BIT] = 1'b1;
                    st_nxt.clr_one   = !st_r.tsel;
                    st_nxt.clr_three = st_r.tsel;
                    st_nxt.conv_start = converter_enabled;
                end
                default:        st_nxt.out_level = st_r.out_level;
            endcase
        end

        // PWM reloads duty only at a period boundary to avoid glitches
        if (mode == CCM_PWM)
        begin
            if (pwm_period_start)
            begin
                st_nxt.pwm_duty  = {st_r.duty_high, st_r.duty_low};
                st_nxt.out_level = ({st_r.duty_high, st_r.duty_low} != '0);
            end
            else if (pwm_time == st_r.pwm_duty)
            begin
                st_nxt.out_level = 1'b0;
            end
        end

        // Register writes
        if (bus_req.wr)
        begin
            if (bus_req.addr == OFS_CONTROL)
            begin
                st_nxt.mode     = bus_req.wdata[CTRL_MODE_LSB +: 4];
                st_nxt.duty_low = bus_req.wdata[CTRL_DUTY_LSB +: 2];
            end
            else if (bus_req.addr == OFS_DUTY_HIGH)
            begin
                st_nxt.duty_high = bus_req.wdata;
            end
            else if (bus_req.addr == OFS_CC_LOW)
            begin
                st_nxt.cc[7:0] = bus_req.wdata;
            end
            else if (bus_req.addr == OFS_CC_HIGH)
            begin
                st_nxt.cc[15:8] = bus_req.wdata;
            end
            else if (bus_req.addr == OFS_STATUS)
            begin
                stat_clr = bus_req.wdata[STAT_W-1:0];
            end
            else if (bus_req.addr == OFS_MASK)
            begin
                st_nxt.mask = bus_req.wdata[STAT_W-1:0];
            end
            else if (bus_req.addr == OFS_TIMER_SEL)
            begin
                st_nxt.tsel = bus_req.wdata[0];
            end
        end
        // Set wins over a clear in the same cycle
        st_nxt.status = (st_r.status & ~stat_clr) | stat_set;

        // Mode entry
        if (mode_change)
        begin
            st_nxt.match_prev = 1'b0;
            case (new_mode)
                CCM_CMP_SET:  st_nxt.out_level = 1'b0;
                CCM_CMP_CLR:  st_nxt.out_level = 1'b1;
                default:      st_nxt.out_level = st_r.out_level;
            endcase
        end
        if (off_wr)
        begin
            st_nxt.out_level  = 1'b0;
            st_nxt.pwm_duty   = '0;
            st_nxt.match_prev = 1'b0;
            st_nxt.clr_one    = 1'b0;
            st_nxt.clr_three  = 1'b0;
            st_nxt.conv_start = 1'b0;
        end

        // Register reads
        if (bus_req.rd)
        begin
            if (bus_req.addr == OFS_CONTROL)
            begin
                st_nxt.rdata = {2'b00, st_r.duty_low, st_r.mode};
            end
            else if (bus_req.addr == OFS_DUTY_HIGH)
            begin
                st_nxt.rdata = st_r.duty_high;
            end
            else if (bus_req.addr == OFS_CC_LOW)
            begin
                st_nxt.rdata = st_r.cc[7:0];
            end
            else if (bus_req.addr == OFS_CC_HIGH)
            begin
                st_nxt.rdata = st_r.cc[15:8];
            end
            else if (bus_req.addr == OFS_STATUS)
            begin
                st_nxt.rdata = {6'h00, st_r.status};
            end
            else if (bus_req.addr == OFS_MASK)
            begin
                st_nxt.rdata = {6'h00, st_r.mask};
            end
            else if (bus_req.addr == OFS_TIMER_SEL)
            begin
                st_nxt.rdata = {7'h00, st_r.tsel};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r           <= '0;
            st_r.mode      <= MODE_RST;
            st_r.duty_low  <= DUTY_LOW_RST;
            st_r.duty_high <= DUTY_HIGH_RST;
            st_r.cc        <= CC_RST;
            st_r.status    <= STATUS_RST;
            st_r.mask      <= MASK_RST;
            st_r.tsel      <= TSEL_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Duty field only reaches the pin through the PWM path
    assign capture_compare_pin_out = st_r.out_level;
    assign capture_compare_pin_oe  = is_compare || (mode == CCM_PWM);
    assign bus_rdata               = st_r.rdata;
    assign timer_one_clear         = st_r.clr_one;
    assign timer_three_clear       = st_r.clr_three;
    assign conversion_start        = st_r.conv_start;
    assign irq                     = |(st_r.status & st_r.mask);

    sequence s_mode_write(logic [3:0] code);
        ctrl_wr && bus_req.wdata[CTRL_MODE_LSB +: 4] == code;
    endsequence

    sequence s_entry(logic [3:0] code);
        s_mode_write(code) ##0 mode_change;
    endsequence

    property p_off_reset;
        @(posedge core_clk) disable iff (!rstn)
        s_mode_write(MC_OFF) |=>
            !capture_compare_pin_out && st_r.pwm_duty == '0 &&
            !capture_compare_pin_oe;
    endproperty
    a_off_reset: assert property (p_off_reset)
        else $error("off mode did not clear unit state");

    property p_toggle;
        @(posedge core_clk) disable iff (!rstn)
        match_fire && mode == CCM_CMP_TOGGLE && !bus_req.wr |=>
            capture_compare_pin_out != $past(capture_compare_pin_out);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle compare did not invert the pin");

    property p_capture_single;
        @(posedge core_clk) disable iff (!rstn)
        cap_edge && (mode == CCM_CAP_FALL || mode == CCM_CAP_RISE) &&
            !bus_req.wr |=>
            st_r.cc == $past(sel_timer) && st_r.status[STAT_EVENT_BIT];
    endproperty
    a_capture_single: assert property (p_capture_single)
        else $error("single edge capture missed the timer value");

    property p_rise_only;
        @(posedge core_clk) disable iff (!rstn)
        mode inside {CCM_CAP_RISE, CCM_CAP_RISE4, CCM_CAP_RISE16} &&
            fall_seen |-> !cap_fire;
    endproperty
    a_rise_only: assert property (p_rise_only)
        else $error("rising edge mode captured a falling edge");

    property p_set_entry;
        @(posedge core_clk) disable iff (!rstn)
        s_entry(MC_CMP_SET) ##1 !match_fire |=> !capture_compare_pin_out;
    endproperty
    a_set_entry: assert property (p_set_entry)
        else $error("set mode entry did not drive the pin low");

    property p_clr_entry;
        @(posedge core_clk) disable iff (!rstn)
        s_entry(MC_CMP_CLR) ##1 !match_fire |=> capture_compare_pin_out;
    endproperty
    a_clr_entry: assert property (p_clr_entry)
        else $error("clear mode entry did not drive the pin high");

    property p_irq_only;
        @(posedge core_clk) disable iff (!rstn)
        mode == CCM_CMP_IRQ && !bus_req.wr |=>
            $stable(capture_compare_pin_out);
    endproperty
    a_irq_only: assert property (p_irq_only)
        else $error("interrupt only compare moved the pin");

    property p_special;
        @(posedge core_clk) disable iff (!rstn)
        match_fire && mode == CCM_CMP_SPEC |=>
            (timer_one_clear != timer_three_clear) ##1
            (!timer_one_clear && !timer_three_clear);
    endproperty
    a_special: assert property (p_special)
        else $error("special trigger did not pulse one timer clear");

    property p_conv_gate;
        @(posedge core_clk) disable iff (!rstn)
        conversion_start |->
            $past(converter_enabled) && (timer_one_clear || timer_three_clear);
    endproperty
    a_conv_gate: assert property (p_conv_gate)
        else $error("conversion started without an enabled converter");

    property p_pwm_load;
        @(posedge core_clk) disable iff (!rstn)
        mode == CCM_PWM && pwm_period_start && !bus_req.wr |=>
            st_r.pwm_duty == $past({st_r.duty_high, st_r.duty_low});
    endproperty
    a_pwm_load: assert property (p_pwm_load)
        else $error("pwm duty not joined from high byte and low bits");

    property p_ctrl_read;
        @(posedge core_clk) disable iff (!rstn)
        bus_req.rd && bus_req.addr == OFS_CONTROL |=> bus_rdata[7:6] == 2'b00;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("unimplemented control bits read nonzero");

    property p_capture_no_drive;
        @(posedge core_clk) disable iff (!rstn)
        is_capture |-> !capture_compare_pin_oe;
    endproperty
    a_capture_no_drive: assert property (p_capture_no_drive)
        else $error("capture mode drives the pin");

endmodule // ccm_unit

// ---- verif/ccm_pin_model.sv ----
// Purpose: Far side of the capture/compare pin
// Assumes: Unit drives the wire while its enable is high
// Notes:   No pull; the outside driver holds the wire otherwise
`timescale 1ns/10ps
module ccm_pin_model
(
    input  wire logic ext_level,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_in
);
    // Wire level from both drivers; unit wins while enabled
    assign pin_in = pin_oe ? pin_out : ext_level;
endmodule // ccm_pin_model

// ---- verif/ccm_unit_bench.sv ----
// Purpose: Self-checking bench of the capture/compare/PWM unit
// Assumes: Timers and PWM time base modelled here
// Notes: Reserved mode codes are never written
`timescale 1ns/10ps
module ccm_unit_bench;
    import ccm_pkg::*;
    logic              core_clk, rstn, conv_en, pwm_start, ext_level;
    logic              pin_in, pin_out, pin_oe, clr_one, clr_three;
    logic              conv, irq;
    ccm_bus_req_type   bus_req;
    ccm_timers_type    timers;
    logic [DATA_W-1:0] bus_rdata, d;
    logic [DUTY_W-1:0] pwm_time, duty;
    logic [15:0]       c, t0;
    logic [3:0]        md;
    logic [1:0]        lb;
    int                mismatches, checks_done, conv_seen;
    logic [3:0]        md_t [4] = '{4'h8, 4'h9, 4'h2, 4'hA};
    logic [3:0]        pre_v = 4'b0010;
    logic [3:0]        post_v = 4'b0101;

    ccm_unit uut (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .timers(timers), .converter_enabled(conv_en),
        .pwm_time(pwm_time), .pwm_period_start(pwm_start),
        .capture_compare_pin_in(pin_in), .capture_compare_pin_out(pin_out),
        .capture_compare_pin_oe(pin_oe), .timer_one_clear(clr_one),
        .timer_three_clear(clr_three), .conversion_start(conv), .irq(irq));
    ccm_pin_model pm (.ext_level(ext_level), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in));

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Timers clear on the unit's pulses
    always @(posedge core_clk)
    begin
        timers.one <= clr_one ? 16'h0000 : timers.one + 16'h0001;
        timers.three <= clr_three ? 16'h0000 : timers.three + 16'h0001;
        pwm_time <= pwm_time + 10'h001;
        pwm_start <= (pwm_time == 10'h3FF);
        if (conv)
            conv_seen <= conv_seen + 1;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 v = bus_rdata;
    endtask

    task automatic wt(input logic [9:0] v);
        @(posedge core_clk);
        for (int n = 0; n < 1100 && pwm_time !== v; n++)
            @(posedge core_clk);
        chk(16'(pwm_time === v), 16'h0001);
    endtask

    // Off first, so half-written compare values cannot match
    task automatic spec(input logic ts, input logic en);
        int n0;
        wr(OFS_CONTROL, 8'h00);
        c = (ts ? timers.three : timers.one) + 16'h0040;
        conv_en <= en;
        wr(OFS_TIMER_SEL, {7'h00, ts});
        wr(OFS_CC_LOW, c[7:0]);
        wr(OFS_CC_HIGH, c[15:8]);
        wr(OFS_CONTROL, 8'h0B);
        n0 = conv_seen;
        cyc(700);
        chk(16'(conv_seen > n0), {15'h0000, en});
        chk(16'((ts ? timers.three : timers.one) <= c), 16'h0001);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #200000;
        mismatches++;
        test_done();
    end

    initial
    begin
        rstn = 1'b0;
        bus_req = '0;
        timers = '0;
        conv_en = 1'b0;
        pwm_time = '0;
        pwm_start = 1'b0;
        ext_level = 1'b0;
        conv_seen = 0;
        void'($urandom(32'hb7974d10));
        cyc(12);
        rstn <= 1'b1;
        for (int a = 0; a < 16; a++)
        begin
            rd(4'(a), d);
            chk(16'(d), 16'h0000);
        end
        wr(OFS_MASK, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_CONTROL, 8'h00);
            c = timers.one + 16'h0030 + 16'($urandom % 16);
            wr(OFS_CC_LOW, c[7:0]);
            wr(OFS_CC_HIGH, c[15:8]);
            wr(OFS_CONTROL, {2'b00, 2'($urandom % 4), md_t[i]});
            wr(OFS_STATUS, 8'h03);
            cyc(2);
            chk({14'h0, irq, pin_out}, {15'h0, pre_v[i]});
            cyc(80);
            chk({14'h0, irq, pin_out}, {14'h1, post_v[i]});
        end
        spec(1'b1, 1'b1);
        spec(1'b0, 1'b0);
        wr(OFS_CONTROL, 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            ext_level <= i[0];
            wr(OFS_CONTROL, i ? 8'h04 : 8'h05);
            cyc(4);
            wr(OFS_STATUS, 8'h03);
            t0 = timers.one;
            ext_level <= ~i[0];
            cyc(10);
            rd(OFS_CC_LOW, d);
            c[7:0] = d;
            rd(OFS_CC_HIGH, d);
            c[15:8] = d;
            chk(16'((c - t0) inside {[16'd1:16'd6]}), 16'h0001);
            rd(OFS_STATUS, d);
            chk(16'(d[0]), 16'h0001);
        end
        for (int i = 0; i < 2; i++)
        begin
            wr(OFS_CONTROL, i ? 8'h07 : 8'h06);
            wr(OFS_STATUS, 8'h03);
            for (int k = 1; k <= (i ? 16 : 4); k++)
            begin
                ext_level <= 1'b1;
                cyc(4);
                ext_level <= 1'b0;
                cyc(4);
                rd(OFS_STATUS, d);
                chk(16'(d[0]), 16'(k == (i ? 16 : 4)));
            end
        end
        for (int i = 0; i < 2; i++)
        begin
            lb = 2'($urandom % 4);
            md = 4'hC | 4'($urandom % 4);
            wr(OFS_DUTY_HIGH, 8'h02);
            wr(OFS_CONTROL, {2'b11, lb, md});
            rd(OFS_CONTROL, d);
            chk(16'(d), 16'({2'b00, lb, md}));
            duty = {8'h02, lb};
            wt(10'h3FF);
            wt(duty - 10'h002);
            chk(16'({pin_oe, pin_out}), 16'h0003);
            wt(duty + 10'h003);
            chk(16'(pin_out), 16'h0000);
        end
        wr(OFS_CONTROL, 8'h00);
        cyc(2);
        chk(16'({pin_oe, pin_out}), 16'h0000);
        test_done();
    end
endmodule // ccm_unit_bench
